// *** src/interrupt_control_flags.sv ***
// global interrupt control, trap status, edge polarity and first flag register
//
// Design decisions made here: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
// Function
// - priority level is msb bit from core control over three status low bits.
// - msb bit set while priority is above seven, clear otherwise.
// - nesting disable one blocks preemption; zero lets higher priority preempt.
// - divide-by-zero status set when a math trap comes from division by zero.
// - dma fault status set on a dma controller error trap.
// - arithmetic trap status set on every math error trap.
// - address trap status set on an address error trap.
// - stack trap status set on a stack error trap.
// - oscillator failure status set on an oscillator failure trap.
// - alternate vector select one uses alternate table, zero the default.
// - read-only bit shows a timed interrupt disable is active.
// - each external input detects falling edge when polarity one, else rising.
// - each flag reads one after its source requested, zero otherwise.
// - flags zero to seven: ext0, cap1, cmp1, tmr1, dma0, cap2, cmp2, tmr2.
// - flags eight to fourteen: tmr3, spi err, spi, rx1, tx1, adc, dma1.
// - unimplemented bits in these registers always read zero.
// - sources set flags; flags stay set until software clears them.
// - low priority bits sit at status seven to five; level seven up masks users.
// - nesting disable one makes the low priority bits read-only.
// - software cannot set the priority msb bit.
module interrupt_control_flags
  import intc_flags_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // avalon-mm register slave
  input wire logic [ADDR_W-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  output logic response_error_o,
  // processor core priority interface
  input wire logic [2:0] priority_low_bits_i,
  input wire logic priority_load_i,
  input wire logic [3:0] priority_level_i,
  input wire logic timed_disable_active_i,
  input wire logic in_service_i,
  input wire logic [3:0] pending_level_i,
  output logic [3:0] cpu_priority_o,
  output logic [2:0] priority_low_bits_o,
  output logic low_bits_locked_o,
  output logic user_irq_masked_o,
  output logic preempt_allowed_o,
  output logic alt_vector_select_o,
  output logic program_space_visibility_o,
  // trap event pulses
  input wire logic arith_trap_i,
  input wire logic divide_zero_cause_i,
  input wire logic dma_fault_trap_i,
  input wire logic address_trap_i,
  input wire logic stack_trap_i,
  input wire logic osc_fail_trap_i,
  // peripheral request pulses, flags 1 to 14 (bit 0 unused)
  input wire logic [FLAG_COUNT-1:0] periph_req_i,
  // external interrupt pins
  input wire logic [EXT_COUNT-1:0] ext_pin_i,
  // flag state to the arbiter
  output logic [FLAG_COUNT-1:0] flags_o,
  output logic [EXT_COUNT-1:0] ext_edge_polarity_o
);
  logic accept;
  logic wr_en;
  logic rd_en;
  logic [15:0] wdata;
  logic [15:0] wmask;
  logic [EXT_COUNT-1:0] ext_edge;

  logic priority_msb_ff;
  logic visibility_ff;
  logic [2:0] low_bits_ff;
  logic nesting_disable_ff;
  logic [5:0] trap_ff;
  logic alt_vector_ff;
  logic timed_disable_ff;
  logic [EXT_COUNT-1:0] polarity_ff;
  logic [FLAG_COUNT-1:0] flag_ff;
  logic [FLAG_COUNT-1:0] flag_set;
  logic [31:0] readdata_ff;
  logic error_ff;
  logic [15:0] rd_word;
  logic rd_hit;

  avalon_reg_port u_port (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .read_i(read_i),
    .write_i(write_i),
    .waitrequest_o(waitrequest_o),
    .accept_o(accept)
  );

  ext_edge_detect #(
    .WIDTH(EXT_COUNT)
  ) u_edges (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pin_i(ext_pin_i),
    .falling_sel_i(polarity_ff),
    .edge_o(ext_edge)
  );

  assign wr_en = accept & write_i;
  assign rd_en = accept & read_i;
  assign wdata = writedata_i[15:0];
  // byte lanes above 15 carry nothing
  assign wmask = {{8{byteenable_i[1]}}, {8{byteenable_i[0]}}};

  // core control: msb bit follows the core's level; software can only clear it
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      priority_msb_ff <= 1'b0;
      visibility_ff <= 1'b0;
    end else begin
      if (priority_load_i) begin
        priority_msb_ff <= (priority_level_i > {1'b0, LOW_PRIORITY_MAX});
      end else if (wr_en && address_i == CORE_CONTROL_ADDR && wmask[PRIORITY_MSB_BIT]
                   && !wdata[PRIORITY_MSB_BIT]) begin
        priority_msb_ff <= 1'b0;
      end
      if (wr_en && address_i == CORE_CONTROL_ADDR && wmask[VISIBILITY_BIT]) begin
        visibility_ff <= wdata[VISIBILITY_BIT];
      end
    end
  end

  // low priority bits held here for the core; locked while nesting is off
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      low_bits_ff <= 3'h0;
    end else if (priority_load_i) begin
      low_bits_ff <= priority_level_i[2:0];
    end else if (!nesting_disable_ff && priority_low_bits_i != low_bits_ff) begin
      low_bits_ff <= priority_low_bits_i;
    end
  end

  // interrupt control one: control bit plus sticky trap status
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      nesting_disable_ff <= 1'b0;
      trap_ff <= 6'h00;
    end else begin
      if (wr_en && address_i == INT_CONTROL_ONE_ADDR && wmask[NESTING_DISABLE_BIT]) begin
        nesting_disable_ff <= wdata[NESTING_DISABLE_BIT];
      end
      for (int i = 0; i < 6; i++) begin
        // trap event beats a same-cycle software clear
        if (wr_en && address_i == INT_CONTROL_ONE_ADDR && wmask[OSC_FAIL_BIT + i]) begin
          trap_ff[i] <= wdata[OSC_FAIL_BIT + i];
        end
      end
      if (osc_fail_trap_i) trap_ff[OSC_FAIL_BIT - 1] <= 1'b1;
      if (stack_trap_i) trap_ff[STACK_TRAP_BIT - 1] <= 1'b1;
      if (address_trap_i) trap_ff[ADDRESS_TRAP_BIT - 1] <= 1'b1;
      if (arith_trap_i) trap_ff[ARITH_TRAP_BIT - 1] <= 1'b1;
      if (dma_fault_trap_i) trap_ff[DMA_FAULT_BIT - 1] <= 1'b1;
      if (arith_trap_i && divide_zero_cause_i) begin
        trap_ff[DIVIDE_ZERO_BIT - 1] <= 1'b1;
      end
    end
  end

  // interrupt control two
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      alt_vector_ff <= 1'b0;
      polarity_ff <= '0;
      timed_disable_ff <= 1'b0;
    end else begin
      timed_disable_ff <= timed_disable_active_i;
      if (wr_en && address_i == INT_CONTROL_TWO_ADDR) begin
        if (wmask[ALT_VECTOR_BIT]) alt_vector_ff <= wdata[ALT_VECTOR_BIT];
        if (wmask[EXT0_EDGE_BIT]) polarity_ff <= wdata[EXT0_EDGE_BIT +: EXT_COUNT];
      end
    end
  end

  // flag sources: ext0 comes from the pin detector, others from peripherals
  always_comb begin
    flag_set = periph_req_i;
    flag_set[0] = ext_edge[0];
  end

  // sticky flags, set wins over a same-cycle clear
  genvar f;
  generate
    for (f = 0; f < FLAG_COUNT; f++) begin : g_flag
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          flag_ff[f] <= 1'b0;
        end else if (flag_set[f]) begin
          flag_ff[f] <= 1'b1;
        end else if (wr_en && address_i == INT_FLAGS_ZERO_ADDR && wmask[f]) begin
          flag_ff[f] <= wdata[f];
        end
      end
    end
  endgenerate

  // read mux, unimplemented bits forced low
  always_comb begin
    rd_word = 16'h0000;
    rd_hit = 1'b1;
    unique case (address_i)
      CORE_CONTROL_ADDR: begin
        rd_word[PRIORITY_MSB_BIT] = priority_msb_ff;
        rd_word[VISIBILITY_BIT] = visibility_ff;
      end
      INT_CONTROL_ONE_ADDR: begin
        rd_word[NESTING_DISABLE_BIT] = nesting_disable_ff;
        rd_word[DIVIDE_ZERO_BIT:OSC_FAIL_BIT] = trap_ff;
      end
      INT_CONTROL_TWO_ADDR: begin
        rd_word[ALT_VECTOR_BIT] = alt_vector_ff;
        rd_word[TIMED_DISABLE_BIT] = timed_disable_ff;
        rd_word[EXT0_EDGE_BIT +: EXT_COUNT] = polarity_ff;
      end
      INT_FLAGS_ZERO_ADDR: begin
        rd_word[FLAG_COUNT-1:0] = flag_ff;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      readdata_ff <= 32'h0000_0000;
      error_ff <= 1'b0;
    end else if (rd_en) begin
      readdata_ff <= {16'h0000, rd_word};
      error_ff <= ~rd_hit;
    end else if (wr_en) begin
      error_ff <= ~rd_hit;
    end
  end

  // read data must stand at the accepting edge, so bypass the register then
  assign readdata_o = rd_en ? {16'h0000, rd_word} : readdata_ff;
  assign response_error_o = accept ? ~rd_hit : error_ff;

  // priority composition and consequences
  assign priority_low_bits_o = low_bits_ff;
  assign cpu_priority_o = {priority_msb_ff, low_bits_ff};
  assign user_irq_masked_o = priority_msb_ff | (low_bits_ff == LOW_PRIORITY_MAX);
  assign low_bits_locked_o = nesting_disable_ff;
  assign preempt_allowed_o = ~(nesting_disable_ff & in_service_i)
                             & (pending_level_i > {priority_msb_ff, low_bits_ff});
  assign alt_vector_select_o = alt_vector_ff;
  assign program_space_visibility_o = visibility_ff;
  assign flags_o = flag_ff;
  assign ext_edge_polarity_o = polarity_ff;
endmodule : interrupt_control_flags

// *** pkg/intc_flags_pkg.sv ***
// register map, field positions and reset values of the interrupt control flags block
package intc_flags_pkg;
  localparam int ADDR_W = 4;
  // word byte addresses on the avalon bus
  localparam logic [ADDR_W-1:0] CORE_CONTROL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] INT_CONTROL_ONE_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] INT_CONTROL_TWO_ADDR = 4'h8;
  localparam logic [ADDR_W-1:0] INT_FLAGS_ZERO_ADDR = 4'hc;
  localparam logic [ADDR_W-1:0] CPU_STATUS_ADDR = 4'h0;
  // core control fields
  localparam int PRIORITY_MSB_BIT = 3;
  localparam int VISIBILITY_BIT = 2;
  // cpu status fields
  localparam int PRIORITY_LOW_LSB = 5;
  // interrupt control one fields
  localparam int NESTING_DISABLE_BIT = 15;
  localparam int DIVIDE_ZERO_BIT = 6;
  localparam int DMA_FAULT_BIT = 5;
  localparam int ARITH_TRAP_BIT = 4;
  localparam int ADDRESS_TRAP_BIT = 3;
  localparam int STACK_TRAP_BIT = 2;
  localparam int OSC_FAIL_BIT = 1;
  // interrupt control two fields
  localparam int ALT_VECTOR_BIT = 15;
  localparam int TIMED_DISABLE_BIT = 14;
  localparam int EXT0_EDGE_BIT = 0;
  // implemented-bit masks
  localparam logic [15:0] CORE_CONTROL_MASK = 16'h000c;
  localparam logic [15:0] INT_CONTROL_ONE_MASK = 16'h807e;
  localparam logic [15:0] INT_CONTROL_TWO_MASK = 16'hc007;
  localparam logic [15:0] INT_FLAGS_ZERO_MASK = 16'h7fff;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [2:0] LOW_PRIORITY_MAX = 3'h7;
  localparam int FLAG_COUNT = 15;
  localparam int EXT_COUNT = 3;
endpackage : intc_flags_pkg

// *** src/ext_edge_detect.sv ***
// synchroniser and polarity-selected edge detector for external request pins
`timescale 1ns/100ps
module ext_edge_detect
  import intc_flags_pkg::*;
#(
  parameter int WIDTH = EXT_COUNT
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // pins and polarity
  input wire logic [WIDTH-1:0] pin_i,
  input wire logic [WIDTH-1:0] falling_sel_i,
  // one-cycle request pulses
  output logic [WIDTH-1:0] edge_o
);
  // a zero-width bank has nothing to watch
  if (WIDTH < 1) begin : g_width_check
    $error("ext_edge_detect needs at least one input");
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      logic meta_ff;
      logic sync_a_ff;
      logic sync_b_ff;
      logic stable_ff;
      logic nxt_stable;
      always_ff @(posedge clock_i) begin
        meta_ff <= pin_i[g];
        sync_a_ff <= meta_ff;
        sync_b_ff <= sync_a_ff;
      end
      // a level only counts once the last two stages agree
      always_comb begin
        nxt_stable = (sync_a_ff == sync_b_ff) ? sync_b_ff : stable_ff;
      end
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          stable_ff <= 1'b0;
        end else begin
          stable_ff <= nxt_stable;
        end
      end
      // polarity bit one selects the falling edge
      assign edge_o[g] = falling_sel_i[g] ? (stable_ff & ~nxt_stable)
                                          : (~stable_ff & nxt_stable);
    end
  endgenerate
endmodule : ext_edge_detect

// *** src/avalon_reg_port.sv ***
// avalon-mm slave handshake: one wait state on every access
`timescale 1ns/100ps
module avalon_reg_port (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // bus request
  input wire logic read_i,
  input wire logic write_i,
  // handshake
  output logic waitrequest_o,
  output logic accept_o
);
  logic done_ff;

  // waitrequest drops in the second cycle of a request, then rearms
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= (read_i | write_i) & ~done_ff;
    end
  end

  assign accept_o = (read_i | write_i) & done_ff;
  assign waitrequest_o = (read_i | write_i) & ~done_ff;
endmodule : avalon_reg_port

// *** test/intc_flags_asserts.sv ***
// concurrent checks on the ports of the interrupt control flags block
`timescale 1ns/100ps
module intc_flags_asserts
  import intc_flags_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // register bus
  input wire logic [ADDR_W-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] readdata_o,
  input wire logic waitrequest_o,
  // priority and flags
  input wire logic priority_load_i,
  input wire logic [3:0] priority_level_i,
  input wire logic in_service_i,
  input wire logic [3:0] pending_level_i,
  input wire logic [3:0] cpu_priority_o,
  input wire logic [2:0] priority_low_bits_o,
  input wire logic low_bits_locked_o,
  input wire logic user_irq_masked_o,
  input wire logic preempt_allowed_o,
  input wire logic [FLAG_COUNT-1:0] periph_req_i,
  input wire logic [FLAG_COUNT-1:0] flags_o
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  a_level_concat: assert property (cpu_priority_o[2:0] == priority_low_bits_o)
    else $error("cpu priority low bits differ from status bits");
  a_user_mask: assert property (
    user_irq_masked_o == (cpu_priority_o[3] || cpu_priority_o[2:0] == LOW_PRIORITY_MAX))
    else $error("user interrupt mask disagrees with priority level");
  a_msb_on_load: assert property (
    priority_load_i |=> cpu_priority_o[3] == ($past(priority_level_i) > 4'h7))
    else $error("priority msb wrong after a load");
  a_msb_no_set: assert property (
    !priority_load_i && !cpu_priority_o[3] |=> !cpu_priority_o[3])
    else $error("priority msb rose without a load");
  a_preempt_gate: assert property (preempt_allowed_o ==
    (!(low_bits_locked_o && in_service_i) && pending_level_i > cpu_priority_o))
    else $error("preemption decision wrong");
  a_low_frozen: assert property (
    low_bits_locked_o && !priority_load_i |=> $stable(priority_low_bits_o))
    else $error("low priority bits changed while locked");
  a_flag_set: assert property (
    |periph_req_i[14:1] |=> (flags_o[14:1] & $past(periph_req_i[14:1])) ==
    $past(periph_req_i[14:1]))
    else $error("request did not set its flag");
  a_flag_hold: assert property (!write_i |=> (flags_o & $past(flags_o)) == $past(flags_o))
    else $error("flag dropped without a write");
  a_unimpl_zero: assert property (
    read_i && !waitrequest_o |-> readdata_o[31:16] == 16'h0000 &&
    !(address_i == INT_FLAGS_ZERO_ADDR && readdata_o[15]))
    else $error("unimplemented read bit is set");
endmodule : intc_flags_asserts
bind interrupt_control_flags intc_flags_asserts i_chk (.*);

// *** test/event_source_model.sv ***
// trap pulses, peripheral requests and external pins feeding the flag block
`timescale 1ns/100ps
module event_source_model (
  // clock
  input wire logic clock_i,
  // events toward the flag block
  output logic [5:0] trap_o,
  output logic [14:0] req_o,
  output logic [2:0] pin_o
);
  initial {trap_o, req_o, pin_o} = '0;
  // single-cycle pulse so each event is counted once
  task automatic fire(input logic [5:0] t, input logic [14:0] r);
    @(posedge clock_i);
    trap_o <= t;
    req_o <= r;
    @(posedge clock_i);
    {trap_o, req_o} <= '0;
  endtask : fire
  task automatic set_pin(input logic [2:0] p);
    @(posedge clock_i);
    pin_o <= p;
  endtask : set_pin
endmodule : event_source_model

// *** test/interrupt_control_flags_tb_top.sv ***
// self-checking bench for the interrupt control flags block
`timescale 1ns/100ps
module interrupt_control_flags_tb_top;
  import intc_flags_pkg::*;
  logic clock_i, rst_i, read_i, write_i, priority_load_i, timed_disable_active_i, in_service_i;
  logic waitrequest_o, response_error_o, low_bits_locked_o, user_irq_masked_o, err;
  logic preempt_allowed_o, alt_vector_select_o, program_space_visibility_o;
  logic [3:0] address_i, byteenable_i, priority_level_i, pending_level_i, cpu_priority_o;
  logic [2:0] priority_low_bits_i, priority_low_bits_o, ext_pin_i, ext_edge_polarity_o;
  logic [31:0] writedata_i, readdata_o, rd;
  logic [14:0] periph_req_i, flags_o;
  logic [5:0] trap;
  int failures, compares;
  localparam logic [5:0] EV [6] = '{6'h01, 6'h03, 6'h04, 6'h08, 6'h10, 6'h20};
  localparam logic [15:0] EX [6] = '{16'h0010, 16'h0050, 16'h0020, 16'h0008, 16'h0004, 16'h0002};
  localparam logic [3:0] ADR [4] = '{CORE_CONTROL_ADDR, INT_CONTROL_ONE_ADDR,
    INT_CONTROL_TWO_ADDR, INT_FLAGS_ZERO_ADDR};
  localparam logic [15:0] FULL [4] = '{16'h0004, 16'h807e, 16'h8007, 16'h7fff};
  event_source_model i_src (.clock_i, .trap_o(trap), .req_o(periph_req_i), .pin_o(ext_pin_i));
  interrupt_control_flags i_dut (.*, .arith_trap_i(trap[0]), .divide_zero_cause_i(trap[1]),
    .dma_fault_trap_i(trap[2]), .address_trap_i(trap[3]), .stack_trap_i(trap[4]),
    .osc_fail_trap_i(trap[5]));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want) begin
      failures++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, want);
    end
  endtask : chk
  task automatic print_verdict;
    if (failures == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  task automatic tick(input int k);
    repeat (k) @(posedge clock_i);
  endtask : tick
  // request held until the rising edge that samples waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    address_i <= a;
    writedata_i <= {16'h0000, d};
    write_i <= w;
    read_i <= !w;
    // values read here are those that stood at the rising edge
    do begin
      @(posedge clock_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 20);
    rd = readdata_o;
    err = response_error_o;
    if (waitrequest_o !== 1'b0) begin
      failures++;
      print_verdict();
    end
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask : bus
  task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(rd, {16'h0000, e});
  endtask : rdchk
  task automatic load(input logic [3:0] lvl);
    @(posedge clock_i);
    priority_level_i <= lvl;
    priority_load_i <= 1'b1;
    @(posedge clock_i);
    priority_load_i <= 1'b0;
  endtask : load
  task automatic t_reset;
    for (int i = 0; i < 4; i++)
      rdchk(ADR[i], 16'h0000);
    rdchk(4'h2, 16'h0000);
    chk(32'(err), 32'h0000_0001);
  endtask : t_reset
  task automatic t_traps;
    for (int i = 0; i < 6; i++) begin
      i_src.fire(EV[i], 15'h0000);
      rdchk(INT_CONTROL_ONE_ADDR, EX[i]);
      bus(1'b1, INT_CONTROL_ONE_ADDR, 16'h0000);
    end
  endtask : t_traps
  task automatic t_flags;
    for (int n = 1; n < 15; n++) begin
      i_src.fire(6'h00, 15'h0001 << n);
      rdchk(INT_FLAGS_ZERO_ADDR, 16'h0001 << n);
      bus(1'b1, INT_FLAGS_ZERO_ADDR, 16'h0000);
    end
  endtask : t_flags
  // ones everywhere: read-only and unimplemented bits must stay low
  task automatic t_fill;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ADR[i], 16'hffff);
      rdchk(ADR[i], FULL[i]);
    end
    chk({alt_vector_select_o, ext_edge_polarity_o}, 32'h0000_000f);
    chk(program_space_visibility_o, 32'h0000_0001);
    bus(1'b1, INT_FLAGS_ZERO_ADDR, 16'h0000);
  endtask : t_fill
  task automatic t_nest;
    priority_low_bits_i <= 3'h2;
    in_service_i <= 1'b1;
    pending_level_i <= 4'h3;
    tick(3);
    chk(priority_low_bits_o, 32'h0000_0000);
    chk(preempt_allowed_o, 32'h0000_0000);
    bus(1'b1, INT_CONTROL_ONE_ADDR, 16'h0000);
    tick(3);
    chk(cpu_priority_o, 32'h0000_0002);
    chk(preempt_allowed_o, 32'h0000_0001);
  endtask : t_nest
  // pin 0 with falling polarity first, then rising
  task automatic t_ext;
    i_src.set_pin(3'h1);
    tick(8);
    chk(flags_o, 32'h0000_0000);
    i_src.set_pin(3'h0);
    tick(8);
    chk(flags_o, 32'h0000_0001);
    bus(1'b1, INT_CONTROL_TWO_ADDR, 16'h0000);
    bus(1'b1, INT_FLAGS_ZERO_ADDR, 16'h0000);
    i_src.set_pin(3'h1);
    tick(8);
    chk(flags_o, 32'h0000_0001);
  endtask : t_ext
  task automatic t_prio;
    load(4'h9);
    rdchk(CORE_CONTROL_ADDR, 16'h000c);
    chk(user_irq_masked_o, 32'h0000_0001);
    load(4'h7);
    rdchk(CORE_CONTROL_ADDR, 16'h0004);
    chk(user_irq_masked_o, 32'h0000_0000);
    timed_disable_active_i <= 1'b1;
    tick(3);
    rdchk(INT_CONTROL_TWO_ADDR, 16'h4000);
    timed_disable_active_i <= 1'b0;
  endtask : t_prio
  initial begin
    {rst_i, read_i, write_i, priority_load_i, timed_disable_active_i, in_service_i} = '0;
    {address_i, priority_level_i, pending_level_i, priority_low_bits_i, writedata_i} = '0;
    rst_i = 1'b1;
    byteenable_i = 4'h3;
    tick(10);
    rst_i <= 1'b0;
    t_reset();
    t_traps();
    t_flags();
    t_fill();
    t_nest();
    t_ext();
    t_prio();
    print_verdict();
  end
endmodule : interrupt_control_flags_tb_top
